//--- design/vcc_clutch.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcc_consts.svh"
// What this block does
// - engaged passes pulses, disengaged blocks them
// - time constant fixed, slippage follows speed
// - time constant resmooths on later travel change
// - slippage systems keep slippage amount constant
// - slippage systems pass later changes directly
// - linear system ramps to programmed slippage
// - done flag clears at start, sets in-range
// - five operation modes supported
// - command mode follows the command bit
// - command mode switches within one cycle
// - bad mode flags error, keeps old mode
// - mode changes accepted at any time
// - external mode needs incremental encoder
// - address mode compares engage/disengage addresses
// - address mode 2 compares after command
// - one-shot uses travel before/after engage
// - one command bit per axis side
// - status flag shows engaged state
// - direct clutch switches without smoothing
// - status refreshed every operation cycle
// - codes 1 and 2 select address modes
module vcc_clutch (
  input  wire logic                core_clk_in,
  input  wire logic                srst_in,
  input  wire vcc_pkg::vcc_cfg_t   cfg_in,          // clutch parameters
  input  wire logic                clutch_command_bit_in, // per-side command bit
  input  wire logic                encoder_start_input_in, // pin, async
  input  wire logic signed [31:0]  drive_pos_in,    // drive current value
  input  wire logic                pulse_valid_in,  // input travel valid
  output logic                     pulse_ready_out, // fifo back-pressure
  input  wire logic signed [31:0]  pulse_travel_in, // input travel per cycle
  output logic                     out_valid_out,   // output travel strobe
  output logic signed [31:0]       out_travel_out,  // output travel
  output logic                     op_cycle_out,    // operation cycle tick
  output logic                     clutch_status_out,   // engaged flag
  output logic                     smoothing_done_flag_out,
  output logic                     mode_error_out,  // bad mode select
  output logic [2:0]               mode_out         // accepted mode
);
  vcc_pkg::vcc_state_t state_reg;       // clutch state
  logic [15:0]         cyc_reg;         // operation cycle counter
  logic                tick;            // one operation cycle
  logic [2:0]          mode_reg;        // accepted mode
  logic                err_reg;         // mode error
  logic                cmd_q_reg;       // previous command bit
  logic                start_s1_reg;    // synchroniser stage 1
  logic                start_s2_reg;    // synchroniser stage 2
  logic                armed_reg;       // address mode 2 armed
  logic                shot_reg;        // one-shot in progress
  logic signed [31:0]  shot_on_reg;     // one-shot engage point
  logic signed [31:0]  shot_off_reg;    // one-shot disengage point
  logic signed [31:0]  rem_reg;         // remaining slippage
  logic signed [31:0]  acc_reg;         // smoothed output rate
  logic                done_reg;        // smoothing done
  logic                smooth_act_reg;  // smoothing active
  logic signed [31:0]  last_in_reg;     // last input travel
  logic signed [31:0]  out_reg;         // output travel
  logic                outv_reg;        // output strobe
  logic                engage_next;     // engage decision
  logic                fifo_v;
  logic signed [31:0]  fifo_d;
  logic signed [31:0]  in_trav;
  logic signed [31:0]  step;
  logic signed [31:0]  rem_new;         // remaining slippage after this cycle

  // magnitude helper for the slippage bookkeeping
  function automatic logic signed [31:0] vcc_abs(input logic signed [31:0] v);
    vcc_abs = (v < 0) ? -v : v;
  endfunction : vcc_abs

  // input travel buffer, drained once per operation cycle
  vcc_fifo #(.WIDTH(32), .DEPTH(`VCC_FIFO_DEPTH)) u_fifo (
    .core_clk_in  (core_clk_in),
    .srst_in      (srst_in),
    .in_valid_in  (pulse_valid_in),
    .in_ready_out (pulse_ready_out),
    .in_data_in   (pulse_travel_in),
    .out_valid_out(fifo_v),
    .out_ready_in (tick),
    .out_data_out (fifo_d)
  );
  assign in_trav = (tick && fifo_v) ? fifo_d : 32'sh0;

  // operation cycle timer
  always_ff @(posedge core_clk_in) begin
    if (srst_in) cyc_reg <= 16'h0000;
    else cyc_reg <= tick ? 16'h0000 : cyc_reg + 16'h0001;
  end
  assign tick = (cyc_reg == `VCC_OPCYC_CLKS - 16'h0001);

  // start input synchroniser
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
    end else begin
      start_s1_reg <= encoder_start_input_in;
      start_s2_reg <= start_s1_reg;
    end
  end

  // mode acceptance, any time
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mode_reg <= `VCC_MODE_ONOFF;
      err_reg  <= 1'b0;
    end else if (cfg_in.mode > `VCC_MODE_MAX ||
                 (cfg_in.mode == `VCC_MODE_EXTIN && !cfg_in.enc_incr)) begin
      err_reg <= 1'b1;                // keep previous mode
    end else begin
      mode_reg <= cfg_in.mode;
      err_reg  <= 1'b0;
    end
  end

  // engage decision per mode
  always_comb begin
    engage_next = (state_reg == vcc_pkg::VCC_ON);
    unique case (mode_reg)
      `VCC_MODE_ONOFF: engage_next = clutch_command_bit_in;
      `VCC_MODE_ADDR: begin
        if (clutch_command_bit_in && drive_pos_in == $signed(cfg_in.on_addr))
          engage_next = 1'b1;
        if (!clutch_command_bit_in && drive_pos_in == $signed(cfg_in.off_addr))
          engage_next = 1'b0;
      end
      `VCC_MODE_ADDR2: begin
        if (armed_reg && drive_pos_in == $signed(cfg_in.on_addr))
          engage_next = 1'b1;
        if (armed_reg && drive_pos_in == $signed(cfg_in.off_addr))
          engage_next = 1'b0;
      end
      `VCC_MODE_ONESHOT: begin
        if (shot_reg && drive_pos_in == shot_on_reg) engage_next = 1'b1;
        if (shot_reg && drive_pos_in == shot_off_reg) engage_next = 1'b0;
      end
      `VCC_MODE_EXTIN: engage_next = clutch_command_bit_in && start_s2_reg;
      default: engage_next = 1'b0;
    endcase
  end

  // arming for address mode 2 and one-shot
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cmd_q_reg    <= 1'b0;
      armed_reg    <= 1'b0;
      shot_reg     <= 1'b0;
      shot_on_reg  <= 32'sh0;
      shot_off_reg <= 32'sh0;
    end else begin
      cmd_q_reg <= clutch_command_bit_in;
      armed_reg <= clutch_command_bit_in ? 1'b1 :
                   (state_reg == vcc_pkg::VCC_OFF ? 1'b0 : armed_reg);
      if (clutch_command_bit_in && !cmd_q_reg) begin
        shot_reg     <= 1'b1;
        shot_on_reg  <= drive_pos_in + $signed(cfg_in.pre_travel);
        shot_off_reg <= drive_pos_in + $signed(cfg_in.pre_travel)
                        + $signed(cfg_in.post_travel);
      end else if (tick && drive_pos_in == shot_off_reg) begin
        // held until the cycle boundary so the disengage is not lost
        shot_reg <= 1'b0;
      end
    end
  end

  // clutch state, switched on an operation cycle boundary
  always_ff @(posedge core_clk_in) begin
    if (srst_in) state_reg <= vcc_pkg::VCC_OFF;
    else if (tick) state_reg <= engage_next ? vcc_pkg::VCC_ON : vcc_pkg::VCC_OFF;
  end

  // per-cycle output rate step for the smoothing systems
  always_comb begin
    step = 32'sh0;
    unique case (cfg_in.smooth)
      `VCC_SM_TCONST: step = (in_trav - acc_reg) >>> cfg_in.tc_shift;
      `VCC_SM_EXP:    step = (in_trav - acc_reg) >>> 2;
      `VCC_SM_LINEAR: step = (in_trav > acc_reg) ? 32'sh1 :
                             ((in_trav < acc_reg) ? -32'sh1 : 32'sh0);
      `VCC_SM_DIRECT: step = in_trav - acc_reg;
    endcase
  end
  // shortfall of this cycle's output against its input, booked off the slip
  assign rem_new = rem_reg - vcc_abs(in_trav - acc_reg - step);

  // smoothing, slippage accounting and output
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      acc_reg        <= 32'sh0;
      rem_reg        <= 32'sh0;
      done_reg       <= 1'b1;
      smooth_act_reg <= 1'b0;
      last_in_reg    <= 32'sh0;
      out_reg        <= 32'sh0;
      outv_reg       <= 1'b0;
    end else begin
      outv_reg <= tick;
      if (tick) begin
        last_in_reg <= in_trav;
        if (engage_next != (state_reg == vcc_pkg::VCC_ON)) begin
          smooth_act_reg <= (cfg_in.smooth != `VCC_SM_DIRECT);
          done_reg       <= (cfg_in.smooth == `VCC_SM_DIRECT);
          rem_reg        <= $signed(cfg_in.slip);
        end else if (smooth_act_reg) begin
          rem_reg <= rem_new;
          if (rem_new < $signed(cfg_in.inpos)) begin
            done_reg       <= 1'b1;
            smooth_act_reg <= 1'b0;
          end
        end else if (cfg_in.smooth == `VCC_SM_TCONST && in_trav != last_in_reg
                     && state_reg == vcc_pkg::VCC_ON) begin
          smooth_act_reg <= 1'b1;
          done_reg       <= 1'b0;
        end
        if (!engage_next) begin
          acc_reg <= smooth_act_reg ? acc_reg + ((32'sh0 - acc_reg) >>> 1) : 32'sh0;
        end else if (smooth_act_reg) begin
          acc_reg <= acc_reg + step;
        end else begin
          acc_reg <= in_trav;
        end
        out_reg <= engage_next ? (smooth_act_reg ? acc_reg + step : in_trav) :
                   (smooth_act_reg ? acc_reg >>> 1 : 32'sh0);
      end
    end
  end

  assign out_valid_out           = outv_reg;
  assign out_travel_out          = out_reg;
  assign op_cycle_out            = tick;
  assign clutch_status_out       = (state_reg == vcc_pkg::VCC_ON);
  assign smoothing_done_flag_out = done_reg;
  assign mode_error_out          = err_reg;
  assign mode_out                = mode_reg;

  // engaged clutch in direct mode forwards input unchanged
  a_direct_pass: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick && engage_next && !smooth_act_reg |=> out_reg == $past(in_trav))
    else $error("direct engaged travel not passed");
  a_off_blocks: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick && !engage_next && !smooth_act_reg |=> out_reg == 32'sh0)
    else $error("disengaged clutch leaked travel");
  a_bad_mode_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
    cfg_in.mode > `VCC_MODE_MAX |=> mode_reg == $past(mode_reg) && err_reg)
    else $error("illegal mode not rejected");
  a_onoff_follow: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick && mode_reg == `VCC_MODE_ONOFF |=> clutch_status_out == $past(clutch_command_bit_in))
    else $error("command mode state mismatch");
  a_cycle_switch: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !tick |=> state_reg == $past(state_reg))
    else $error("state changed between cycles");
  a_done_clears: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick && engage_next != clutch_status_out && cfg_in.smooth != `VCC_SM_DIRECT
    |=> !done_reg)
    else $error("done flag not cleared at start");
  a_ext_gate: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick && mode_reg == `VCC_MODE_EXTIN && !start_s2_reg |=> !clutch_status_out)
    else $error("external mode engaged without start");
  a_tick_period: assert property (@(posedge core_clk_in) disable iff (srst_in)
    tick |=> !tick [*8])
    else $error("operation cycle too short");
  c_engage: cover property (@(posedge core_clk_in) $rose(clutch_status_out));
  c_smooth_done: cover property (@(posedge core_clk_in) $rose(done_reg));
  c_mode_err: cover property (@(posedge core_clk_in) $rose(err_reg));
endmodule : vcc_clutch
`default_nettype wire

//--- design/vcc_consts.svh
`ifndef VCC_CONSTS_SVH
`define VCC_CONSTS_SVH
// travel and position word width
`define VCC_TW          32
// axes and clutch sides
`define VCC_AXES        32
`define VCC_AXES_SMALL  8
`define VCC_SIDES       2
// mode select codes
`define VCC_MODE_ONOFF  3'h0
`define VCC_MODE_ADDR   3'h1
`define VCC_MODE_ADDR2  3'h2
`define VCC_MODE_ONESHOT 3'h3
`define VCC_MODE_EXTIN  3'h4
`define VCC_MODE_MAX    3'h4
// smoothing systems
`define VCC_SM_DIRECT   2'h0
`define VCC_SM_TCONST   2'h1
`define VCC_SM_EXP      2'h2
`define VCC_SM_LINEAR   2'h3
// fifo depth in front of the clutch
`define VCC_FIFO_DEPTH  8
// operation cycle length in core clocks
`define VCC_OPCYC_CLKS  16'h0010
`endif

//--- design/vcc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// small flop fifo with valid/ready on both sides
module vcc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage
  logic [AW-1:0]    wr_reg;           // write index
  logic [AW-1:0]    rd_reg;           // read index
  logic [AW:0]      cnt_reg;          // fill level
  logic             push;
  logic             pop;
  assign in_ready_out  = (cnt_reg < (AW+1)'(DEPTH));  // room for one more word
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  // storage write
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end
  // pointers and level
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : vcc_fifo
`default_nettype wire

//--- design/vcc_pkg.sv
package vcc_pkg;
  // clutch parameter set steering one clutch
  typedef struct packed {
    logic [2:0]  mode;       // requested operation mode
    logic [1:0]  smooth;     // smoothing system
    logic [31:0] on_addr;    // engage address
    logic [31:0] off_addr;   // disengage address
    logic [31:0] slip;       // slippage amount
    logic [31:0] inpos;      // slippage in-position range
    logic [7:0]  tc_shift;   // time-constant shift
    logic [31:0] pre_travel; // one-shot travel before engage
    logic [31:0] post_travel;// one-shot travel after engage
    logic        enc_incr;   // drive is incremental encoder
  } vcc_cfg_t;
  // clutch state machine
  typedef enum logic [1:0] {
    VCC_OFF = 2'b01,
    VCC_ON  = 2'b10
  } vcc_state_t;
endpackage : vcc_pkg

//--- testbench/vcc_clutch_bench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for one clutch side
module vcc_clutch_bench;
  logic                clk, srst, cmd, start, go;   // stimulus bits
  vcc_pkg::vcc_cfg_t   cfg;                         // clutch parameters
  logic signed [31:0]  pos, word, trav, otrav, sum; // travel words
  logic [7:0]          count;                       // burst length
  logic                pv, rdy, ov, tick, stat, done, merr;
  logic [2:0]          mode;                        // accepted mode
  int                  mismatches, check_count;     // report counters
  vcc_clutch dut (.core_clk_in(clk), .srst_in(srst), .cfg_in(cfg),
    .clutch_command_bit_in(cmd), .encoder_start_input_in(start),
    .drive_pos_in(pos), .pulse_valid_in(pv), .pulse_ready_out(rdy),
    .pulse_travel_in(trav), .out_valid_out(ov), .out_travel_out(otrav),
    .op_cycle_out(tick), .clutch_status_out(stat),
    .smoothing_done_flag_out(done), .mode_error_out(merr), .mode_out(mode));
  vcc_drive_model drv (.core_clk_in(clk), .srst_in(srst), .go_in(go),
    .count_in(count), .word_in(word), .ready_in(rdy), .valid_out(pv),
    .travel_out(trav), .axis_valid_in(ov), .axis_travel_in(otrav),
    .sum_out(sum));
  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic close_out;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // compare tasks
  task automatic check_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0b seen %0b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_word(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word
  // bounded wait: 0 status, 1 done flag, 2 drive idle
  task automatic wait_for(int sel, logic exp, int bound);
    logic v;
    for (int i = 0; i < bound; i++) begin
      @(posedge clk);
      #1;
      v = (sel == 0) ? stat : (sel == 1) ? done : ~pv;
      if (v === exp) begin
        return;
      end
    end
    mismatches++;
    $display("CHECK FAILED wait %0d expected %0b seen timeout", sel, exp);
    close_out();
  endtask : wait_for
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // start one burst in the drive model
  task automatic burst(logic [7:0] n, logic signed [31:0] w);
    @(posedge clk);
    go    <= 1'b1;
    count <= n;
    word  <= w;
    @(posedge clk);
    go    <= 1'b0;
  endtask : burst
  // values right after reset
  task automatic t_reset;
    check_bit("status", 1'b0, stat);
    check_bit("done", 1'b1, done);
    check_bit("error", 1'b0, merr);
    check_word("mode", 32'h0, {29'h0, mode});
    check_bit("ready", 1'b1, rdy);
  endtask : t_reset
  // every legal code, then two refused ones
  task automatic t_modes;
    for (int m = 0; m < 5; m++) begin
      @(posedge clk);
      cfg.mode <= m[2:0];
      settle(3);
      check_word("mode", m, {29'h0, mode});
      check_bit("error", 1'b0, merr);
    end
    @(posedge clk);
    cfg.mode <= 3'h5;
    settle(3);
    check_bit("error", 1'b1, merr);
    check_word("mode", 32'h4, {29'h0, mode});
    @(posedge clk);
    cfg.mode <= 3'h0;
    settle(3);
    @(posedge clk);
    cfg.enc_incr <= 1'b0;
    cfg.mode     <= 3'h4;
    settle(3);
    check_bit("error", 1'b1, merr);
    check_word("mode", 32'h0, {29'h0, mode});
    @(posedge clk);
    cfg.mode     <= 3'h0;
    cfg.enc_incr <= 1'b1;
    settle(3);
  endtask : t_modes
  // blocked when off, fifo fill and full pass when on
  task automatic t_pass;
    logic signed [31:0] s0;
    logic               low;
    s0 = sum;
    burst(8'h3, 32'h5);
    wait_for(2, 1'b1, 100);
    settle(160);
    check_word("blocked", s0, sum);
    @(posedge clk);
    cmd <= 1'b1;
    wait_for(0, 1'b1, 17);
    s0  = sum;
    low = 1'b0;
    burst(8'hc, 32'h7);
    settle(1);
    for (int i = 0; i < 300 && pv === 1'b1; i++) begin
      @(posedge clk);
      #1;
      low = low | (rdy === 1'b0);
    end
    check_bit("full", 1'b1, low);
    settle(160);
    check_word("passed", s0 + 32'h54, sum);
    for (int i = 0; i < 17 && tick !== 1'b1; i++) begin
      settle(1);
    end
    settle(1);
    check_bit("strobe", 1'b1, ov);
  endtask : t_pass
  // time constant re-smooths, slippage systems keep the programmed slippage
  task automatic t_smooth;
    logic signed [31:0] s0, lag;
    for (int s = 1; s < 4; s++) begin
      @(posedge clk);
      cfg.smooth <= 2'h0;
      cmd        <= 1'b0;
      wait_for(0, 1'b0, 40);
      settle(160);
      @(posedge clk);
      cfg.smooth <= s[1:0];
      settle(2);
      s0  = sum;
      @(posedge clk);
      cmd <= 1'b1;
      wait_for(1, 1'b0, 20);
      burst(8'h64, 32'h10);
      wait_for(1, 1'b1, 2000);
      if (s == 1) begin
        wait_for(1, 1'b0, 2000);
      end
      wait_for(2, 1'b1, 2000);
      settle(160);
      if (s != 1) begin
        lag = 32'h640 - (sum - s0);
        check_bit("slip", 1'b1, lag >= 32'h3e && lag <= 32'h42);
        check_bit("done", 1'b1, done);
      end
    end
  endtask : t_smooth
  // address compare steers engage and disengage, mode 2 only once armed
  task automatic t_addr;
    @(posedge clk);
    cfg.smooth <= 2'h0;
    cmd        <= 1'b0;
    wait_for(0, 1'b0, 40);
    @(posedge clk);
    cfg.mode <= 3'h1;
    pos      <= 32'h50;
    settle(2);
    @(posedge clk);
    cmd <= 1'b1;
    settle(40);
    check_bit("status", 1'b0, stat);
    @(posedge clk);
    pos <= 32'h100;
    wait_for(0, 1'b1, 40);
    @(posedge clk);
    cmd <= 1'b0;
    settle(40);
    check_bit("status", 1'b1, stat);
    @(posedge clk);
    pos <= 32'h200;
    wait_for(0, 1'b0, 40);
    @(posedge clk);
    cfg.mode <= 3'h2;
    pos      <= 32'h100;
    settle(40);
    check_bit("status", 1'b0, stat);
    @(posedge clk);
    cmd <= 1'b1;
    wait_for(0, 1'b1, 40);
    @(posedge clk);
    cmd <= 1'b0;
    pos <= 32'h200;
    wait_for(0, 1'b0, 40);
  endtask : t_addr
  // one-shot engages and disengages on travel from the command edge
  task automatic t_shot;
    @(posedge clk);
    cfg.mode <= 3'h3;
    pos      <= 32'h1000;
    settle(2);
    @(posedge clk);
    cmd <= 1'b1;
    settle(40);
    check_bit("status", 1'b0, stat);
    @(posedge clk);
    pos <= 32'h1010;
    wait_for(0, 1'b1, 40);
    @(posedge clk);
    pos <= 32'h1030;
    wait_for(0, 1'b0, 40);
  endtask : t_shot
  // external start gates engagement
  task automatic t_extin;
    @(posedge clk);
    cfg.mode <= 3'h4;
    cmd      <= 1'b1;
    settle(40);
    check_bit("status", 1'b0, stat);
    @(posedge clk);
    start <= 1'b1;
    wait_for(0, 1'b1, 40);
  endtask : t_extin
  // main sequence
  initial begin
    mismatches   = 0;
    check_count  = 0;
    srst         = 1'b1;
    cmd          = 1'b0;
    start        = 1'b0;
    go           = 1'b0;
    count        = 8'h0;
    word         = 32'h0;
    pos          = 32'h0;
    cfg          = '0;
    cfg.on_addr  = 32'h100;
    cfg.off_addr = 32'h200;
    cfg.slip     = 32'h40;
    cfg.inpos    = 32'h2;
    cfg.tc_shift = 8'h2;
    cfg.pre_travel  = 32'h10;
    cfg.post_travel = 32'h20;
    cfg.enc_incr = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    settle(1);
    t_reset();
    t_modes();
    t_pass();
    t_smooth();
    t_addr();
    t_shot();
    t_extin();
    close_out();
  end
endmodule : vcc_clutch_bench
`default_nettype wire

//--- testbench/vcc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// drive module feeding travel words, output axis summing what passes
module vcc_drive_model (
  input  wire logic               core_clk_in,
  input  wire logic               srst_in,
  input  wire logic               go_in,          // start a burst
  input  wire logic [7:0]         count_in,       // words in burst
  input  wire logic signed [31:0] word_in,        // travel per word
  input  wire logic               ready_in,       // clutch fifo ready
  output logic                    valid_out,      // travel valid
  output logic signed [31:0]      travel_out,     // travel word
  input  wire logic               axis_valid_in,  // output strobe
  input  wire logic signed [31:0] axis_travel_in, // output travel
  output logic signed [31:0]      sum_out         // output axis position
);
  logic [7:0] left_reg; // words still to hand over
  // drive side: word held until taken, released line shows inverse
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      valid_out  <= 1'b0;
      travel_out <= 32'h0;
      left_reg   <= 8'h0;
    end else if (go_in) begin
      valid_out  <= 1'b1;
      travel_out <= word_in;
      left_reg   <= count_in;
    end else if (valid_out && ready_in) begin
      left_reg <= left_reg - 8'h1;
      if (left_reg == 8'h1) begin
        valid_out  <= 1'b0;
        travel_out <= ~travel_out;
      end
    end
  end
  // output axis accumulates every forwarded travel
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sum_out <= 32'h0;
    end else if (axis_valid_in) begin
      sum_out <= sum_out + axis_travel_in;
    end
  end
endmodule : vcc_drive_model
`default_nettype wire
